// File: verilog/lpc_target_pkg.sv
// Purpose: Shared constants and types for the LPC flash target interface.
// Assumes: All LPC pins are synchronous to sys_clk.
// Notes:   Nibble codes and phase counts of a single-byte memory cycle.
package lpc_target_pkg;

	// Field nibbles on LAD
	localparam logic [3:0] START_CODE      = 4'h0;
	localparam logic [1:0] CYC_MEM_CODE    = 2'h1; // Upper bits of type
	localparam logic [3:0] SHORT_WAIT_SYNC = 4'h5;
	localparam logic [3:0] READY_SYNC      = 4'h0;
	localparam logic [3:0] TURN_NIBBLE     = 4'hF;

	// Field positions
	localparam int TYPE_DIR_BIT  = 1;
	localparam int TYPE_LOW_BIT  = 0;
	localparam int ARRAY_SEL_BIT = 22;

	// Phase lengths, as last index of an up-counted phase
	localparam logic [2:0] ADDR_LAST = 3'h7; // Eight address nibbles
	localparam logic [2:0] WAIT_LAST = 3'h1; // Two wait-sync clocks
	localparam logic [2:0] DATA_LAST = 3'h1; // Two data nibbles

	// Highest LPC clock rate the pipeline is built for
	localparam int LPC_MAX_MHZ = 33;

	// Cycle phases
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_START,
		ST_ADDR,
		ST_RD_TAR1,
		ST_RD_TAR2,
		ST_RD_WAIT,
		ST_RD_READY,
		ST_RD_DATA,
		ST_WR_DATA,
		ST_WR_TAR1,
		ST_WR_TAR2,
		ST_WR_SYNC,
		ST_END_TAR
	} phase_t;

endpackage

// File: verilog/ctrl_if.sv
// Purpose: Carries reset and protection controls between the two modules.
// Assumes: One clock domain, sys_clk.
// Notes:   Every signal is driven by a flip-flop in the producer.
`timescale 1ns/10ps
interface ctrl_if;
	logic restore_pulse; // Leaving reset: read mode and lock defaults
	logic pe_abort;      // Kill a running program or erase
	logic force_top;     // Top block protection forced
	logic force_all;     // Block protection forced

	modport gen (output restore_pulse, output pe_abort,
		output force_top, output force_all);
	modport sink (input restore_pulse, input pe_abort,
		input force_top, input force_all);
endinterface

// File: verilog/lpc_reset_protect.sv
// Purpose: Reset entry and exit effects and forced block protection.
// Assumes: Reset pins are synchronous and held for the minimum pulse time.
// Notes:   Outputs are one-cycle pulses or registered levels.
`timescale 1ns/10ps
module lpc_reset_protect (
	input  wire logic sys_clk,           // System clock
	input  wire logic srst,              // Synchronous reset, high
	input  wire logic interface_reset_n, // Interface reset, low
	input  wire logic cpu_reset_n,       // Processor reset, low
	input  wire logic pe_busy,           // Program or erase running
	input  wire logic top_block_lock_n,  // Top block lock pin, low
	input  wire logic write_protect_n,   // Write protect pin, low
	ctrl_if.gen       ctl                // Controls to the main module
);

	logic in_reset;
	logic next_in_reset;
	logic next_restore;
	logic next_abort;
	logic next_top;
	logic next_all;
	logic pin_reset;

	// Either reset pin low puts the device in reset
	always_comb
	begin
		pin_reset     = ~interface_reset_n | ~cpu_reset_n;
		next_in_reset = pin_reset;
		// Pulse once on release so lock state goes back to defaults
		next_restore  = in_reset & ~pin_reset;
		// Abort a running operation on the first reset clock only
		next_abort    = pin_reset & ~in_reset & pe_busy;
		// Pins override whatever the lock registers hold
		next_top      = ~top_block_lock_n;
		next_all      = ~write_protect_n;
	end

	// Register state; srst acts as a reset held at power-up
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			in_reset          <= 1'b1;
			ctl.restore_pulse <= 1'b0;
			ctl.pe_abort      <= 1'b0;
			ctl.force_top     <= 1'b1;
			ctl.force_all     <= 1'b1;
		end
		else
		begin
			in_reset          <= next_in_reset;
			ctl.restore_pulse <= next_restore;
			ctl.pe_abort      <= next_abort;
			ctl.force_top     <= next_top;
			ctl.force_all     <= next_all;
		end
	end

endmodule

// File: verilog/lpc_flash_target_interface.sv
// Purpose: LPC target decoder for single-byte memory read and write.
// Assumes: sys_clk is the LPC clock; inputs synchronous to it.
// Notes:   LAD output and enable are registered and aligned to the phase.
//          Abort and reset pins act at the next clock edge.
//
// Functional notes
// - Start field: frame low with nibble 0000b at a rising edge.
// - Read cycle type nibble is 0100b.
// - Thirty-two bit address arrives in eight nibbles, most significant first.
// - Address bit 22 selects array when one, registers when zero.
// - Device takes over LAD in second read turnaround clock.
// - Read always drives short wait sync 0101b for two clocks.
// - Then ready sync 0000b for one clock.
// - Read byte returned low nibble first, then high nibble.
// - Device drives 1111b one clock, then releases LAD.
// - Write: host sends type, address, data; device answers with sync.
// - Frame low mid-cycle aborts the cycle and floats LAD at once.
// - Write command starts once the byte is in; abort still frees bus.
// - Idle with frame high: standby, LAD floating.
// - Either reset pin low: reset, deselected, outputs floating.
// - Leaving reset restores read mode and lock defaults.
// - Reset during program or erase aborts the operation.
// - Top block lock and write protect pins force protection.
// - Interface works at LPC clocks up to 33 MHz.
// - Write cycle type nibble is 011Xb.
// - Write sync 0000b for one clock acknowledges the data.
// - After write sync, 1111b for one clock, then release LAD.
`timescale 1ns/10ps
module lpc_flash_target_interface (
	input  wire logic        sys_clk,           // LPC clock
	input  wire logic        srst,              // Synchronous reset, high
	input  wire logic        lframe_n,          // Frame, low
	input  wire logic [3:0]  lad_in,            // LAD as seen on the pins
	output logic      [3:0]  lad_out,           // LAD value driven
	output logic             lad_oe,            // LAD output enable, high
	input  wire logic        interface_reset_n, // Interface reset, low
	input  wire logic        cpu_reset_n,       // Processor reset, low
	input  wire logic        top_block_lock_n,  // Top block lock, low
	input  wire logic        write_protect_n,   // Write protect, low
	input  wire logic        pe_busy,           // Program or erase running
	input  wire logic [7:0]  mem_rdata,         // Read byte from core
	output logic             mem_rd_req,        // Read request pulse
	output logic             mem_wr_req,        // Write command pulse
	output logic      [31:0] mem_addr,          // Assembled address
	output logic             mem_array_sel,     // 1 array, 0 registers
	output logic      [7:0]  mem_wdata,         // Write byte
	output logic             defaults_restore,  // Read mode, lock defaults
	output logic             pe_abort,          // Abort program or erase
	output logic             force_top_lock,    // Top block forced locked
	output logic             force_all_lock     // Blocks forced locked
);

	// Reset and lock controls from the helper module
	ctrl_if ctl ();

	// Reset entry, exit and protection pins
	lpc_reset_protect u_reset_protect (
		.sys_clk           (sys_clk),
		.srst              (srst),
		.interface_reset_n (interface_reset_n),
		.cpu_reset_n       (cpu_reset_n),
		.pe_busy           (pe_busy),
		.top_block_lock_n  (top_block_lock_n),
		.write_protect_n   (write_protect_n),
		.ctl               (ctl)
	);

	// Cycle state and its next values
	lpc_target_pkg::phase_t phase;
	lpc_target_pkg::phase_t next_phase;
	logic [2:0]  cnt;
	logic [2:0]  next_cnt;
	logic        is_write;
	logic        next_is_write;
	logic [7:0]  rbyte;
	logic [7:0]  next_rbyte;

	// Next values of the registered pin and core outputs
	logic [3:0]  next_lad_out;
	logic        next_lad_oe;
	logic        next_rd_req;
	logic        next_wr_req;
	logic [31:0] next_addr;
	logic [7:0]  next_wdata;

	// Decoded conditions
	logic        dev_reset;
	logic        start_seen;

	// Next values of the reset and lock outputs
	logic        next_defaults;
	logic        next_pe_abort;
	logic        next_force_top;
	logic        next_force_all;

	// Reset pins deselect in the same clock, not one later
	assign dev_reset  = srst | ~interface_reset_n | ~cpu_reset_n;
	assign start_seen = ~lframe_n & (lad_in == lpc_target_pkg::START_CODE);

	// Phase sequencing; everything is one register stage per LPC clock,
	// so the whole path fits easily in a 33 MHz period
	always_comb
	begin
		next_phase    = phase;
		next_cnt      = cnt;
		next_is_write = is_write;
		next_rbyte    = rbyte;
		next_rd_req   = 1'b0;
		next_wr_req   = 1'b0;
		next_addr     = mem_addr;
		next_wdata    = mem_wdata;
		case (phase)
			lpc_target_pkg::ST_IDLE:
			begin
				if (start_seen)
					next_phase = lpc_target_pkg::ST_START;
			end
			lpc_target_pkg::ST_START:
			begin
				// Start may last several clocks; the last low one counts
				if (!lframe_n)
					next_phase = start_seen ? lpc_target_pkg::ST_START
						: lpc_target_pkg::ST_IDLE;
				else if (lad_in[3:2] == lpc_target_pkg::CYC_MEM_CODE &&
					(lad_in[lpc_target_pkg::TYPE_DIR_BIT] ||
					!lad_in[lpc_target_pkg::TYPE_LOW_BIT]))
				begin
					next_phase    = lpc_target_pkg::ST_ADDR;
					next_is_write = lad_in[lpc_target_pkg::TYPE_DIR_BIT];
					next_cnt      = 3'h0;
				end
				else
					next_phase = lpc_target_pkg::ST_IDLE;
			end
			lpc_target_pkg::ST_ADDR:
			begin
				// Shift left so the first nibble ends up on top
				next_addr = {mem_addr[27:0], lad_in};
				next_cnt  = cnt + 3'h1;
				if (cnt == lpc_target_pkg::ADDR_LAST)
				begin
					next_cnt = 3'h0;
					if (is_write)
						next_phase = lpc_target_pkg::ST_WR_DATA;
					else
					begin
						next_phase  = lpc_target_pkg::ST_RD_TAR1;
						next_rd_req = 1'b1;
					end
				end
			end
			lpc_target_pkg::ST_RD_TAR1: // Host drives 1111b here
				next_phase = lpc_target_pkg::ST_RD_TAR2;
			lpc_target_pkg::ST_RD_TAR2:
			begin
				next_phase = lpc_target_pkg::ST_RD_WAIT;
				next_cnt   = 3'h0;
			end
			lpc_target_pkg::ST_RD_WAIT:
			begin
				next_cnt = cnt + 3'h1;
				if (cnt == lpc_target_pkg::WAIT_LAST)
					next_phase = lpc_target_pkg::ST_RD_READY;
			end
			lpc_target_pkg::ST_RD_READY:
			begin
				next_rbyte = mem_rdata;
				next_phase = lpc_target_pkg::ST_RD_DATA;
				next_cnt   = 3'h0;
			end
			lpc_target_pkg::ST_RD_DATA:
			begin
				next_cnt = cnt + 3'h1;
				if (cnt == lpc_target_pkg::DATA_LAST)
					next_phase = lpc_target_pkg::ST_END_TAR;
			end
			lpc_target_pkg::ST_WR_DATA:
			begin
				// Low nibble arrives first
				next_wdata = {lad_in, mem_wdata[7:4]};
				next_cnt   = cnt + 3'h1;
				if (cnt == lpc_target_pkg::DATA_LAST)
				begin
					// Command launches now; a later abort cannot recall it
					next_wr_req = 1'b1;
					next_phase  = lpc_target_pkg::ST_WR_TAR1;
				end
			end
			lpc_target_pkg::ST_WR_TAR1:
				next_phase = lpc_target_pkg::ST_WR_TAR2;
			lpc_target_pkg::ST_WR_TAR2:
				next_phase = lpc_target_pkg::ST_WR_SYNC;
			lpc_target_pkg::ST_WR_SYNC:
				next_phase = lpc_target_pkg::ST_END_TAR;
			lpc_target_pkg::ST_END_TAR:
				next_phase = lpc_target_pkg::ST_IDLE;
			default:
				next_phase = lpc_target_pkg::ST_IDLE;
		endcase
		// Frame low in mid-cycle abandons it; a start may follow
		if (phase != lpc_target_pkg::ST_IDLE &&
			phase != lpc_target_pkg::ST_START && !lframe_n)
		begin
			next_phase  = start_seen ? lpc_target_pkg::ST_START
				: lpc_target_pkg::ST_IDLE;
			next_rd_req = 1'b0;
			// Byte not complete, so the command never reaches the core
			next_wr_req = 1'b0;
		end
	end

	// LAD drive for the phase being entered, so pins match the phase
	always_comb
	begin
		next_lad_oe  = 1'b1;
		next_lad_out = lpc_target_pkg::TURN_NIBBLE;
		case (next_phase)
			lpc_target_pkg::ST_RD_TAR2,
			lpc_target_pkg::ST_WR_TAR2:
				next_lad_out = lpc_target_pkg::TURN_NIBBLE;
			lpc_target_pkg::ST_RD_WAIT:
				next_lad_out = lpc_target_pkg::SHORT_WAIT_SYNC;
			lpc_target_pkg::ST_RD_READY,
			lpc_target_pkg::ST_WR_SYNC:
				next_lad_out = lpc_target_pkg::READY_SYNC;
			// Low nibble straight from the core, high one from the copy
			lpc_target_pkg::ST_RD_DATA:
				next_lad_out = (phase == lpc_target_pkg::ST_RD_READY)
					? mem_rdata[3:0] : rbyte[7:4];
			lpc_target_pkg::ST_END_TAR:
				next_lad_out = lpc_target_pkg::TURN_NIBBLE;
			default: // Standby and host-driven phases float LAD
				next_lad_oe = 1'b0;
		endcase
	end

	// Registers; any reset pin floats LAD and drops the cycle
	// One stage per clock leaves ample slack at 33 MHz
	always_ff @(posedge sys_clk)
	begin
		if (dev_reset)
		begin
			phase         <= lpc_target_pkg::ST_IDLE;
			cnt           <= 3'h0;
			is_write      <= 1'b0;
			rbyte         <= 8'h00;
			lad_out       <= lpc_target_pkg::TURN_NIBBLE;
			lad_oe        <= 1'b0;
			mem_rd_req    <= 1'b0;
			mem_wr_req    <= 1'b0;
			mem_addr      <= 32'h0000_0000;
			mem_array_sel <= 1'b0;
			mem_wdata     <= 8'h00;
		end
		else
		begin
			phase         <= next_phase;
			cnt           <= next_cnt;
			is_write      <= next_is_write;
			rbyte         <= next_rbyte;
			lad_out       <= next_lad_out;
			lad_oe        <= next_lad_oe;
			mem_rd_req    <= next_rd_req;
			mem_wr_req    <= next_wr_req;
			mem_addr      <= next_addr;
			mem_array_sel <= next_addr[lpc_target_pkg::ARRAY_SEL_BIT];
			mem_wdata     <= next_wdata;
		end
	end

	// Reset effects and forced locks; a second stage keeps outputs on flops
	always_comb
	begin
		next_defaults  = ctl.restore_pulse;
		next_pe_abort  = ctl.pe_abort;
		next_force_top = ctl.force_top;
		next_force_all = ctl.force_all;
	end

	// Register the reset effects and forced locks
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			defaults_restore <= 1'b0;
			pe_abort         <= 1'b0;
			force_top_lock   <= 1'b1;
			force_all_lock   <= 1'b1;
		end
		else
		begin
			defaults_restore <= next_defaults;
			pe_abort         <= next_pe_abort;
			force_top_lock   <= next_force_top;
			force_all_lock   <= next_force_all;
		end
	end

endmodule

// File: testbench/lpc_host_model.sv
// Purpose: LPC host model that drives frame and LAD toward the target.
// Assumes: LAD has pull-ups, so an undriven wire reads 1111b.
// Notes:   Drives change at the rising edge; the bench calls the tasks.
`timescale 1ns/10ps
module lpc_host_model (
	input  wire logic       sys_clk,  // Clock
	input  wire logic [3:0] lad_out,  // Target drive value
	input  wire logic       lad_oe,   // Target drive enable
	output logic            lframe_n, // Frame, low
	output logic      [3:0] lad_in    // Resolved LAD wire
);
	logic       hoe;  // Host drives LAD
	logic [3:0] hlad; // Host nibble

	// Idle: frame high, LAD released
	initial
	begin
		lframe_n = 1'b1;
		hoe      = 1'b0;
		hlad     = 4'hF;
	end

	// Host wins, then target, else the pull-up
	assign lad_in = hoe ? hlad : (lad_oe ? lad_out : 4'hF);

	// One host clock: frame level and nibble
	task automatic put(input logic f, input logic [3:0] n);
		@(posedge sys_clk);
		lframe_n <= f;
		hlad     <= n;
		hoe      <= 1'b1;
	endtask

	// Start, cycle type, address most significant nibble first
	task automatic hdr(input logic [3:0] ty, input logic [31:0] a);
		put(1'b0, 4'h0);
		put(1'b1, ty);
		for (int i = 7; i >= 0; i--)
			put(1'b1, a[i*4 +: 4]);
	endtask

	// First turnaround clock
	task automatic tar1();
		put(1'b1, 4'hF);
	endtask

	// Frame low mid-cycle; LAD left to the target
	task automatic abort_clk();
		@(posedge sys_clk);
		lframe_n <= 1'b0;
		hoe      <= 1'b0;
	endtask

	// Release LAD and capture the target clock that follows
	task automatic rx(output logic oe, output logic [3:0] v);
		@(posedge sys_clk);
		lframe_n <= 1'b1;
		hoe      <= 1'b0;
		@(negedge sys_clk);
		oe = lad_oe;
		v  = lad_out;
	endtask
endmodule

// File: testbench/lpc_target_props.sv
// Purpose: Timing checks on the LPC target pins.
// Assumes: One clock; srst high disables the checks.
// Notes:   Sync and data checks look backward so that an abort cannot trip them.
`timescale 1ns/10ps
module lpc_target_props (
	input wire logic       sys_clk,           // Clock
	input wire logic       srst,              // Reset
	input wire logic       lframe_n,          // Frame
	input wire logic [3:0] lad_in,            // Wire
	input wire logic [3:0] lad_out,           // Drive value
	input wire logic       lad_oe,            // Drive enable
	input wire logic       interface_reset_n, // Reset pin
	input wire logic       cpu_reset_n,       // Reset pin
	input wire logic       top_block_lock_n,  // Lock pin
	input wire logic       write_protect_n,   // Lock pin
	input wire logic [7:0] mem_rdata,         // Core byte
	input wire logic       mem_rd_req,        // Read pulse
	input wire logic       force_top_lock,    // Forced top
	input wire logic       force_all_lock     // Forced all
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	// Drive rules on LAD
	chk_abort_float: assert property (
		lad_oe && !lframe_n |=> !lad_oe) else $error("drive after abort");
	chk_start_quiet: assert property (
		!lframe_n && lad_in == 4'h0 |=> !lad_oe [*8])
		else $error("drive too early");
	chk_wait_two: assert property (
		lad_oe && lad_out == 4'h0 && $past(lad_out) == 4'h5
		&& $past(lad_out, 2) == 4'h5 |-> $past(lad_out, 3) == 4'hF
		&& !$past(lad_oe, 4)) else $error("wait sync count");
	chk_rd_order: assert property (
		lad_oe && $past(lad_oe, 2) && $past(lad_out, 2) == 4'h0
		&& $past(lad_out, 3) == 4'h5
		|-> {lad_out, $past(lad_out)} == $past(mem_rdata, 2))
		else $error("read nibble order");
	chk_end_release: assert property (
		$fell(lad_oe) && $past(lframe_n) && $past(interface_reset_n)
		&& $past(cpu_reset_n) |-> $past(lad_out) == 4'hF)
		else $error("release without turnaround");
	chk_wr_sync: assert property (
		lad_oe && $past(lad_oe, 2) && $past(lad_out) == 4'h0
		&& $past(lad_out, 2) == 4'hF |-> lad_out == 4'hF)
		else $error("write sync tail");
	chk_reset_float: assert property (
		!interface_reset_n || !cpu_reset_n |=> !lad_oe)
		else $error("drive in reset");
	chk_rd_takeover: assert property (
		mem_rd_req && lframe_n && interface_reset_n && cpu_reset_n
		|=> lad_oe && lad_out == 4'hF)
		else $error("no takeover");
	// Lock pins reach the outputs after two clocks
	chk_lock_force: assert property (
		!$past(srst) && !$past(srst, 2) |->
		force_top_lock == !$past(top_block_lock_n, 2)
		&& force_all_lock == !$past(write_protect_n, 2))
		else $error("lock force");

	cov_ready: cover property (lad_oe && lad_out == 4'h0);
	cov_abort: cover property (lad_oe && !lframe_n);
	cov_lock: cover property (force_top_lock && force_all_lock);
endmodule

bind lpc_flash_target_interface lpc_target_props lpc_target_props_inst (
	.sys_clk, .srst, .lframe_n, .lad_in, .lad_out, .lad_oe,
	.interface_reset_n, .cpu_reset_n, .top_block_lock_n,
	.write_protect_n, .mem_rdata, .mem_rd_req, .force_top_lock,
	.force_all_lock);

// File: testbench/tb.sv
// Purpose: Self-checking bench for the LPC flash target.
// Assumes: Core read byte held steady for the whole cycle.
// Notes:   Pulses are counted so a lost or doubled request shows.
`timescale 1ns/10ps
module tb;
	logic        sys_clk, srst, lframe_n, lad_oe, pe_busy;
	logic        interface_reset_n, cpu_reset_n;
	logic        top_block_lock_n, write_protect_n;
	logic [3:0]  lad_in, lad_out;
	logic [7:0]  mem_rdata, mem_wdata;
	logic [31:0] mem_addr;
	logic        mem_rd_req, mem_wr_req, mem_array_sel;
	logic        defaults_restore, pe_abort, force_top_lock;
	logic        force_all_lock;
	int          err_count = 0, num_checks = 0;
	int          n_rd = 0, n_wr = 0, n_pab = 0, n_rst = 0;

	lpc_flash_target_interface lpc_flash_target_interface_inst (.sys_clk,
		.srst, .lframe_n, .lad_in, .lad_out, .lad_oe, .interface_reset_n,
		.cpu_reset_n, .top_block_lock_n, .write_protect_n, .pe_busy,
		.mem_rdata, .mem_rd_req, .mem_wr_req, .mem_addr, .mem_array_sel,
		.mem_wdata, .defaults_restore, .pe_abort, .force_top_lock,
		.force_all_lock);
	lpc_host_model host (.sys_clk, .lad_out, .lad_oe, .lframe_n, .lad_in);

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Count one-clock pulses; a stuck pulse counts many times
	always @(posedge sys_clk)
	begin
		if (mem_rd_req === 1'b1) n_rd <= n_rd + 1;
		if (mem_wr_req === 1'b1) n_wr <= n_wr + 1;
		if (pe_abort === 1'b1) n_pab <= n_pab + 1;
		if (defaults_restore === 1'b1) n_rst <= n_rst + 1;
	end

	task automatic cmp(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("ERROR %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Read, or an ignored type; ab is the target clock of an abort
	task automatic sc_read(input logic [3:0] ty, input logic [31:0] a,
		input logic [7:0] d, input int ab);
		logic [3:0] ex[8];
		logic       oe, ok;
		logic [3:0] v;
		int         n;
		ex = '{4'hF, 4'h5, 4'h5, 4'h0, d[3:0], d[7:4], 4'hF, 4'hF};
		ok = (ty == 4'h4);
		n = n_rd;
		@(posedge sys_clk);
		mem_rdata <= d;
		host.hdr(ty, a);
		host.tar1();
		for (int i = 0; i < 8; i++)
		begin
			if (i == ab) host.abort_clk();
			host.rx(oe, v);
			cmp("lad_oe", ok && i < 7 && i < ab, oe);
			if (ok && i < 7 && i < ab) cmp("lad_out", ex[i], v);
		end
		if (ok) cmp("mem_addr", a, mem_addr);
		if (ok) cmp("array_sel", a[22], mem_array_sel);
		cmp("rd_req", n + ok, n_rd);
	endtask

	// Write; ab is 0, or the clock (12 data, 13 turnaround) of an abort
	task automatic sc_write(input logic [3:0] ty, input logic [31:0] a,
		input logic [7:0] d, input int ab);
		logic [3:0] ex[3];
		logic       oe;
		logic [3:0] v;
		int         n;
		ex = '{4'hF, 4'h0, 4'hF};
		n = n_wr;
		host.hdr(ty, a);
		host.put(1'b1, d[3:0]);
		if (ab == 12) host.abort_clk();
		else host.put(1'b1, d[7:4]);
		if (ab == 13) host.abort_clk();
		else if (ab == 0) host.tar1();
		for (int i = 0; i < 4; i++)
		begin
			host.rx(oe, v);
			cmp("lad_oe", ab == 0 && i < 3, oe);
			if (ab == 0 && i < 3) cmp("lad_out", ex[i], v);
		end
		if (ab != 12) cmp("mem_wdata", d, mem_wdata);
		cmp("mem_addr", a, mem_addr);
		cmp("array_sel", a[22], mem_array_sel);
		cmp("wr_req", n + (ab != 12), n_wr);
	endtask

	// A reset pin falls mid-read while a program runs
	task automatic sc_reset(input logic cpu);
		logic       oe;
		logic [3:0] v;
		int         na, nr;
		na = n_pab;
		nr = n_rst;
		host.hdr(4'h4, 32'hFFC0_0000);
		host.tar1();
		host.rx(oe, v);
		@(posedge sys_clk);
		if (cpu) cpu_reset_n <= 1'b0;
		else interface_reset_n <= 1'b0;
		pe_busy <= 1'b1;
		host.rx(oe, v);
		cmp("lad_oe", 1'b0, oe);
		repeat (4) @(posedge sys_clk);
		interface_reset_n <= 1'b1;
		cpu_reset_n <= 1'b1;
		pe_busy <= 1'b0;
		repeat (5) @(posedge sys_clk);
		cmp("pe_abort", na + 1, n_pab);
		cmp("restore", nr + 1, n_rst);
	endtask

	task automatic sc_locks();
		for (int v = 0; v < 4; v++)
		begin
			@(posedge sys_clk);
			top_block_lock_n <= v[0];
			write_protect_n <= v[1];
			repeat (3) @(posedge sys_clk);
			@(negedge sys_clk);
			cmp("force_top", !v[0], force_top_lock);
			cmp("force_all", !v[1], force_all_lock);
		end
	endtask

	// Main sequence; reads and writes each hit both array and register addresses
	initial
	begin
		srst = 1'b1;
		{interface_reset_n, cpu_reset_n} = 2'h3;
		{top_block_lock_n, write_protect_n} = 2'h3;
		pe_busy = 1'b0;
		mem_rdata = 8'h00;
		repeat (4) @(posedge sys_clk);
		srst <= 1'b0;
		@(negedge sys_clk);
		cmp("idle_oe", 1'b0, lad_oe);
		sc_read(4'h4, 32'hFFC0_1234, 8'hA5, 8);
		sc_read(4'h4, 32'hFF80_5678, 8'h3C, 8);
		sc_read(4'h4, 32'hFFC0_0010, 8'h96, 1);
		sc_read(4'h2, 32'hFFC0_0020, 8'h11, 8);
		sc_read(4'h5, 32'hFFC0_0030, 8'h22, 8);
		sc_read(4'hC, 32'hFFC0_0040, 8'h33, 8);
		sc_write(4'h6, 32'hFF80_00A5, 8'h3C, 0);
		sc_write(4'h7, 32'hFFC0_0F0F, 8'hE1, 0);
		sc_write(4'h7, 32'hFF80_0001, 8'h5A, 13);
		sc_write(4'h6, 32'hFFC0_0002, 8'hC3, 12);
		sc_reset(1'b0);
		sc_reset(1'b1);
		sc_read(4'h4, 32'hFFC0_0042, 8'h7E, 8);
		sc_locks();
		report_and_stop();
	end

	// Hang guard, well past the few hundred clocks of the run
	initial
	begin
		#100000;
		err_count++;
		report_and_stop();
	end
endmodule
